// [code_protect_pkg.sv]
// Constants, address map and helpers shared by the code and write protection logic
package code_protect_pkg;

    // ****************************************
    // Register map (word addresses)
    // ****************************************
    localparam logic [15:0] USER_ID_BASE   = 16'h8000;
    localparam logic [15:0] USER_ID_LAST   = 16'h8003;
    localparam logic [15:0] DEV_REV_ADDR   = 16'h8006;
    localparam logic [15:0] CFG2_ADDR      = 16'h8008;
    localparam logic [15:0] PROTECT_ADDR   = 16'h8010;
    localparam logic [15:0] STATUS_ADDR    = 16'h8011;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int          CFG2_WRT_LSB    = 0;
    localparam int          CFG2_FREQ_MULTIPLIER_ENABLE_BIT  = 8;
    localparam int          CFG2_STACK_FAULT_RESET_ENABLE_BIT = 9;
    localparam logic [13:0] CFG2_RESET      = 14'h3FFF;
    localparam logic [13:0] CFG2_WR_MASK    = 14'h3703;
    localparam int          PROT_PM_BIT     = 0;
    localparam int          PROT_EE_BIT     = 1;
    localparam logic [1:0]  PROTECT_RESET   = 2'h3;
    localparam int          STAT_REFUSE_BIT = 0;
    localparam int          STAT_STACK_BIT  = 1;
    localparam int          DEV_CODE_LSB    = 5;

    // ****************************************
    // Self-write protection sizes
    // ****************************************
    localparam logic [1:0]  SWP_NONE       = 2'h3;
    localparam logic [1:0]  SWP_SMALL      = 2'h2;
    localparam logic [1:0]  SWP_HALF       = 2'h1;
    localparam logic [12:0] SWP_SMALL_LAST = 13'h01FF;
    localparam logic [12:0] SWP_HALF_LAST  = 13'h0FFF;

    // True when a self-write to addr falls inside the shielded block
    function automatic logic swp_protected(input logic [1:0] size, input logic [12:0] addr);
        case (size)
            SWP_NONE:  swp_protected = 1'b0;
            SWP_SMALL: swp_protected = (addr <= SWP_SMALL_LAST);
            SWP_HALF:  swp_protected = (addr <= SWP_HALF_LAST);
            default:   swp_protected = 1'b1;
        endcase
    endfunction : swp_protected

endpackage : code_protect_pkg

// [self_write_if.sv]
// Carrier between the protection core and the self-write guard
`timescale 1ns/1ps
interface self_write_if;
    logic [1:0]  size;
    logic [12:0] addr;
    logic        req;
    logic        grant;
    logic        refused;
    modport core  (output size, output addr, output req, input grant, input refused);
    modport guard (input size, input addr, input req, output grant, output refused);
endinterface : self_write_if

// [self_write_guard.sv]
// Gate for CPU self-writes to program memory against the protected block
`timescale 1ns/1ps
module self_write_guard
    import code_protect_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    self_write_if.guard swp
);

    typedef struct packed {
        logic grant;
        logic refused;
    } guard_state_t;

    guard_state_t st_r;
    guard_state_t st_nxt;

    // ****************************************
    // Decision, one cycle after the request
    // ****************************************
    always_comb begin
        st_nxt.grant   = swp.req & ~swp_protected(swp.size, swp.addr);
        st_nxt.refused = swp.req & swp_protected(swp.size, swp.addr);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign swp.grant   = st_r.grant;
    assign swp.refused = st_r.refused;

    // Whole range shielded: nothing may ever be granted
    a_whole_range_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
        (swp.req && swp.size == 2'h0) |=> (!swp.grant && swp.refused))
        else $error("self-write granted under full protection");

endmodule : self_write_guard

// [user_id_store.sv]
// Four user identification words with registered read data
`timescale 1ns/1ps
module user_id_store (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  addr,
    input  wire logic        wr,
    input  wire logic [13:0] wdata,
    output logic      [13:0] rdata
);

    logic [13:0] word_r [4];

    // ****************************************
    // Storage and read port
    // ****************************************
    // Words come up blank (all ones) like erased memory
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                word_r[i] <= 14'h3FFF;
            end
            rdata <= 14'h0000;
        end else begin
            if (wr) begin
                word_r[addr] <= wdata;
            end
            rdata <= word_r[addr];
        end
    end

endmodule : user_id_store

// [config_code_write_protect.sv]
// Configuration word decode, code protection and self-write protection core
`timescale 1ns/1ps
//
// Contract
// - With the stack fault reset bit set a stack overflow or underflow requests a reset, else not.
// - The two-bit self-write size field shields nothing at 11 and all of 0000h-1FFFh at 00.
// - Self-write protection acts on writes issued by the device's own software only.
// - With program code protect low, external program reads and writes are refused, reads give 0.
// - CPU reads of program memory are never gated; its writes depend only on the size field.
// - With EEPROM code protect low, external EEPROM reads and writes are blocked, CPU use is not.
// - Program and EEPROM protection are independent and never restrict internal access.
// - Four user ID words at 8000h-8003h are readable and writable in normal execution.
// - The word at 8006h holds a nine-bit device code above a five-bit revision code.
module config_code_write_protect
    import code_protect_pkg::*;
#(
    parameter logic [8:0] DEV_CODE = 9'h0A5, // Arbitrary value
    parameter logic [4:0] REV_CODE = 5'h01   // Arbitrary value
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] reg_addr,
    input  wire logic [13:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [13:0] reg_rdata,
    input  wire logic        cpu_pm_wr_req,
    input  wire logic [12:0] cpu_pm_wr_addr,
    output logic             cpu_pm_wr_grant,
    output logic             cpu_pm_wr_refused,
    input  wire logic        ext_pm_rd,
    input  wire logic        ext_pm_wr,
    input  wire logic [13:0] pm_rdata,
    output logic      [13:0] ext_pm_rdata,
    output logic             ext_pm_wr_en,
    input  wire logic        ext_ee_rd,
    input  wire logic        ext_ee_wr,
    input  wire logic [7:0]  ee_rdata,
    output logic      [7:0]  ext_ee_rdata,
    output logic             ext_ee_wr_en,
    output logic             ext_refused,
    input  wire logic        ext_id_rd,
    output logic      [13:0] ext_id_rdata,
    input  wire logic        stack_fault,
    output logic             stack_fault_reset,
    output logic             freq_mult_en
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [13:0] cfg2;
        logic [1:0]  protect;
        logic [1:0]  status;
        logic [13:0] rd_data;
        logic        rd_uid;
        logic [13:0] ext_pm_rdata;
        logic        ext_pm_wr_en;
        logic [7:0]  ext_ee_rdata;
        logic        ext_ee_wr_en;
        logic        ext_refused;
        logic [13:0] ext_id_rdata;
        logic        stack_rst;
        logic        freq_mult;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;

    logic [13:0] dev_rev_word;
    logic [13:0] cfg2_view;
    logic        uid_hit;
    logic        uid_wr;
    logic [13:0] uid_rdata;
    logic        pm_open;
    logic        ee_open;
    logic        refuse_evt;

    self_write_if swp ();

    // Checks below share one clock and drop out while reset is low
    default clocking core_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ****************************************
    // Fixed words and decodes
    // ****************************************
    // Identity word: device code in the upper nine bits, revision below
    assign dev_rev_word = {DEV_CODE, REV_CODE};
    // Unused and reserved bits are forced to one on every read
    assign cfg2_view    = st_r.cfg2 | ~CFG2_WR_MASK;
    assign uid_hit      = (reg_addr >= USER_ID_BASE) && (reg_addr <= USER_ID_LAST);
    assign uid_wr       = reg_wr & uid_hit;
    // Each memory looks only at its own protect bit
    assign pm_open      = st_r.protect[PROT_PM_BIT];
    assign ee_open      = st_r.protect[PROT_EE_BIT];
    assign refuse_evt   = ((ext_pm_rd | ext_pm_wr) & ~pm_open)
                        | ((ext_ee_rd | ext_ee_wr) & ~ee_open);

    // ****************************************
    // Self-write request to the guard
    // ****************************************
    // Only the CPU write path goes through the guard; external paths are separate
    assign swp.size = st_r.cfg2[CFG2_WRT_LSB +: 2];
    assign swp.addr = cpu_pm_wr_addr;
    assign swp.req  = cpu_pm_wr_req;

    self_write_guard u_guard (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .swp      (swp.guard)
    );

    user_id_store u_uid (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .addr     (reg_addr[1:0]),
        .wr       (uid_wr),
        .wdata    (reg_wdata),
        .rdata    (uid_rdata)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_nxt = st_r;

        // Register writes; only programmable config bits take the write
        if (reg_wr) begin
            case (reg_addr)
                CFG2_ADDR: begin
                    st_nxt.cfg2 = (reg_wdata & CFG2_WR_MASK) | ~CFG2_WR_MASK;
                end
                PROTECT_ADDR: begin
                    st_nxt.protect = reg_wdata[1:0];
                end
                STATUS_ADDR: begin
                    st_nxt.status = st_r.status & ~reg_wdata[1:0];
                end
                default: begin
                    st_nxt.status = st_r.status;
                end
            endcase
        end

        // Sticky status; a new event wins over a clear in the same cycle
        if (refuse_evt) begin
            st_nxt.status[STAT_REFUSE_BIT] = 1'b1;
        end
        if (stack_fault) begin
            st_nxt.status[STAT_STACK_BIT] = 1'b1;
        end

        // Register reads, data stand in the following cycle only
        st_nxt.rd_uid  = reg_rd & uid_hit;
        st_nxt.rd_data = 14'h0000;
        if (reg_rd) begin
            case (reg_addr)
                DEV_REV_ADDR: st_nxt.rd_data = dev_rev_word;
                CFG2_ADDR:    st_nxt.rd_data = cfg2_view;
                PROTECT_ADDR: st_nxt.rd_data = {12'h000, st_r.protect};
                STATUS_ADDR:  st_nxt.rd_data = {12'h000, st_r.status};
                default:      st_nxt.rd_data = 14'h0000;
            endcase
        end

        // External program memory: zeros and no write while protected
        st_nxt.ext_pm_rdata = (ext_pm_rd && pm_open) ? pm_rdata : 14'h0000;
        st_nxt.ext_pm_wr_en = ext_pm_wr & pm_open;

        // External EEPROM: blocked while protected, CPU path untouched
        st_nxt.ext_ee_rdata = (ext_ee_rd && ee_open) ? ee_rdata : 8'h00;
        st_nxt.ext_ee_wr_en = ext_ee_wr & ee_open;
        st_nxt.ext_refused  = refuse_evt;

        // The identity word is never hidden from the tools
        st_nxt.ext_id_rdata = ext_id_rd ? dev_rev_word : 14'h0000;

        // Stack fault reset only when enabled in the config word
        st_nxt.stack_rst = stack_fault & st_r.cfg2[CFG2_STACK_FAULT_RESET_ENABLE_BIT];
        st_nxt.freq_mult = st_r.cfg2[CFG2_FREQ_MULTIPLIER_ENABLE_BIT];
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r              <= '0;
            st_r.cfg2         <= CFG2_RESET;
            st_r.protect      <= PROTECT_RESET;
            st_r.freq_mult    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // User ID data already come from a register inside the store
    assign reg_rdata         = st_r.rd_uid ? uid_rdata : st_r.rd_data;
    assign cpu_pm_wr_grant   = swp.grant;
    assign cpu_pm_wr_refused = swp.refused;
    assign ext_pm_rdata      = st_r.ext_pm_rdata;
    assign ext_pm_wr_en      = st_r.ext_pm_wr_en;
    assign ext_ee_rdata      = st_r.ext_ee_rdata;
    assign ext_ee_wr_en      = st_r.ext_ee_wr_en;
    assign ext_refused       = st_r.ext_refused;
    assign ext_id_rdata      = st_r.ext_id_rdata;
    assign stack_fault_reset = st_r.stack_rst;
    assign freq_mult_en      = st_r.freq_mult;

    // ****************************************
    // Checks
    // ****************************************
    a_stack_reset_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stack_fault && st_r.cfg2[CFG2_STACK_FAULT_RESET_ENABLE_BIT]) |=> stack_fault_reset)
        else $error("stack fault without reset while enabled");

    a_stack_reset_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!stack_fault || !st_r.cfg2[CFG2_STACK_FAULT_RESET_ENABLE_BIT]) |=> !stack_fault_reset)
        else $error("stack reset raised while disabled");

    a_pm_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ext_pm_rd && !pm_open) |=> (ext_pm_rdata == 14'h0000 && ext_refused))
        else $error("protected program read leaked data");

    a_pm_read_open: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ext_pm_rd && pm_open) |=> (ext_pm_rdata == $past(pm_rdata)))
        else $error("open program read lost data");

    a_pm_write_block: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ext_pm_wr && !pm_open) |=> !ext_pm_wr_en)
        else $error("protected program write passed");

    a_ee_block: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((ext_ee_wr || ext_ee_rd) && !ee_open) |=> (!ext_ee_wr_en && ext_ee_rdata == 8'h00))
        else $error("protected eeprom access passed");

    a_ee_independent: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ext_ee_wr && ee_open && !pm_open) |=> ext_ee_wr_en)
        else $error("eeprom write blocked by program protection");

    a_cpu_write_size: assert property (@(posedge core_clk) disable iff (!rst_n)
        (cpu_pm_wr_req && swp.size == SWP_NONE) |=> (cpu_pm_wr_grant && !cpu_pm_wr_refused))
        else $error("cpu write refused with protection off");

    a_cfg_reserved_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == CFG2_ADDR) |=> ((reg_rdata & ~CFG2_WR_MASK) == ~CFG2_WR_MASK))
        else $error("reserved config bit read as zero");

    a_ident_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == DEV_REV_ADDR) |=> (reg_rdata[13:5] == DEV_CODE
                                                  && reg_rdata[4:0] == REV_CODE))
        else $error("identity word wrong");

    a_uid_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        (uid_wr ##1 (reg_rd && reg_addr == $past(reg_addr))) |=> (reg_rdata == $past(reg_wdata, 2)))
        else $error("user id word not stored");

    // ****************************************
    // Self-write answer, external access, identity, multiplier and status checks
    // ****************************************
    a_answer_idle: assert property (
        !cpu_pm_wr_req |=> (!cpu_pm_wr_grant && !cpu_pm_wr_refused))
        else $error("unasked self-write answer");

    a_answer_once: assert property (
        cpu_pm_wr_req |=> (cpu_pm_wr_grant != cpu_pm_wr_refused))
        else $error("self-write answer not single");

    a_small_shield: assert property (
        (cpu_pm_wr_req && swp.size == SWP_SMALL && cpu_pm_wr_addr <= SWP_SMALL_LAST)
        |=> cpu_pm_wr_refused)
        else $error("small block not shielded");

    a_small_open: assert property (
        (cpu_pm_wr_req && swp.size == SWP_SMALL && cpu_pm_wr_addr > SWP_SMALL_LAST)
        |=> cpu_pm_wr_grant)
        else $error("outside small block refused");

    a_half_shield: assert property (
        (cpu_pm_wr_req && swp.size == SWP_HALF && cpu_pm_wr_addr <= SWP_HALF_LAST)
        |=> cpu_pm_wr_refused)
        else $error("half block not shielded");

    a_half_open: assert property (
        (cpu_pm_wr_req && swp.size == SWP_HALF && cpu_pm_wr_addr > SWP_HALF_LAST)
        |=> cpu_pm_wr_grant)
        else $error("outside half block refused");

    a_pm_write_open: assert property (
        (ext_pm_wr && pm_open) |=> ext_pm_wr_en)
        else $error("open program write lost");

    a_pm_idle_zero: assert property (
        !ext_pm_rd |=> (ext_pm_rdata == 14'h0000))
        else $error("program data without read");

    a_ee_read_open: assert property (
        (ext_ee_rd && ee_open) |=> (ext_ee_rdata == $past(ee_rdata)))
        else $error("open eeprom read lost data");

    a_ee_write_open: assert property (
        (ext_ee_wr && ee_open) |=> ext_ee_wr_en)
        else $error("open eeprom write lost");

    a_ee_refused: assert property (
        ((ext_ee_rd || ext_ee_wr) && !ee_open) |=> ext_refused)
        else $error("eeprom refusal not flagged");

    a_pm_independent: assert property (
        (ext_pm_rd && pm_open && !ee_open) |=> (ext_pm_rdata == $past(pm_rdata)))
        else $error("program read blocked by eeprom bit");

    a_refuse_status: assert property (
        ext_refused |-> st_r.status[STAT_REFUSE_BIT])
        else $error("refusal not kept in status");

    a_refuse_idle: assert property (
        !(ext_pm_rd || ext_pm_wr || ext_ee_rd || ext_ee_wr) |=> !ext_refused)
        else $error("refusal without access");

    a_ident_tool: assert property (
        ext_id_rd |=> (ext_id_rdata == {DEV_CODE, REV_CODE}))
        else $error("tool identity read wrong");

    a_pll_follow: assert property (
        (reg_wr && reg_addr == CFG2_ADDR)
        |-> ##2 (freq_mult_en == $past(reg_wdata[CFG2_FREQ_MULTIPLIER_ENABLE_BIT], 2)))
        else $error("multiplier enable not following");

    a_stack_status: assert property (
        stack_fault |=> st_r.status[STAT_STACK_BIT])
        else $error("stack fault not kept in status");

endmodule : config_code_write_protect

// [ext_tool_model.sv]
// Model of an external programmer tool together with the memory lines it reads through
`timescale 1ns/1ps
module ext_tool_model (
    input  wire logic        core_clk,
    output logic             ext_pm_rd,
    output logic             ext_pm_wr,
    output logic             ext_ee_rd,
    output logic             ext_ee_wr,
    output logic             ext_id_rd,
    output logic      [13:0] pm_rdata,
    output logic      [7:0]  ee_rdata
);
    // ****************************************
    // Strobes and memory data
    // ****************************************
    localparam logic [13:0] PM_WORD = 14'h2A5C;
    localparam logic [7:0]  EE_BYTE = 8'hC3;
    logic [4:0] strb_r = 5'h00;

    // One strobe at a time, as a real tool issues single accesses
    assign {ext_id_rd, ext_ee_wr, ext_ee_rd, ext_pm_wr, ext_pm_rd} = strb_r;
    // Outside the read cycle the lines show the inverse, so stale data cannot pass
    assign pm_rdata = strb_r[0] ? PM_WORD : ~PM_WORD;
    assign ee_rdata = strb_r[2] ? EE_BYTE : ~EE_BYTE;

    // Kind 0 pm read, 1 pm write, 2 ee read, 3 ee write, 4 identity read
    task automatic access(input int k);
        @(posedge core_clk);
        strb_r <= 5'(1 << k);
        @(posedge core_clk);
        strb_r <= 5'h00;
    endtask : access
endmodule : ext_tool_model

// [testbench.sv]
// Self-checking testbench for the configuration decode and protection core
`timescale 1ns/1ps
module testbench;
    import code_protect_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [8:0] T_DEV = 9'h05A; // Arbitrary value
    localparam logic [4:0] T_REV = 5'h03;  // Arbitrary value
    localparam logic [1:0]  SW_SZ [6] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
    localparam logic [12:0] SW_AD [6] = '{13'h1FFF, 13'h01FF, 13'h0200, 13'h0FFF,
                                          13'h1000, 13'h1FFF};
    localparam logic        SW_OK [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic cpu_pm_wr_req = 1'b0, stack_fault = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [13:0] reg_wdata = 14'h0000;
    logic [12:0] cpu_pm_wr_addr = 13'h0000;
    logic [13:0] reg_rdata, ext_pm_rdata, ext_id_rdata, pm_rdata;
    logic [7:0]  ext_ee_rdata, ee_rdata;
    logic cpu_pm_wr_grant, cpu_pm_wr_refused, ext_pm_wr_en, ext_ee_wr_en, ext_refused;
    logic stack_fault_reset, freq_mult_en, ext_pm_rd, ext_pm_wr, ext_ee_rd, ext_ee_wr;
    logic ext_id_rd, pm_o, ee_o;
    int   error_cnt = 0, n_checks = 0, cyc = 0;

    config_code_write_protect #(.DEV_CODE(T_DEV), .REV_CODE(T_REV)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_pm_wr_req(cpu_pm_wr_req), .cpu_pm_wr_addr(cpu_pm_wr_addr),
        .cpu_pm_wr_grant(cpu_pm_wr_grant), .cpu_pm_wr_refused(cpu_pm_wr_refused),
        .ext_pm_rd(ext_pm_rd), .ext_pm_wr(ext_pm_wr), .pm_rdata(pm_rdata),
        .ext_pm_rdata(ext_pm_rdata), .ext_pm_wr_en(ext_pm_wr_en), .ext_ee_rd(ext_ee_rd),
        .ext_ee_wr(ext_ee_wr), .ee_rdata(ee_rdata), .ext_ee_rdata(ext_ee_rdata),
        .ext_ee_wr_en(ext_ee_wr_en), .ext_refused(ext_refused), .ext_id_rd(ext_id_rd),
        .ext_id_rdata(ext_id_rdata), .stack_fault(stack_fault),
        .stack_fault_reset(stack_fault_reset), .freq_mult_en(freq_mult_en));

    ext_tool_model TOOL (
        .core_clk(core_clk), .ext_pm_rd(ext_pm_rd), .ext_pm_wr(ext_pm_wr),
        .ext_ee_rd(ext_ee_rd), .ext_ee_wr(ext_ee_wr), .ext_id_rd(ext_id_rd),
        .pm_rdata(pm_rdata), .ee_rdata(ee_rdata));

    // Clock at 40 MHz and a hang guard well above the expected run length
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // ****************************************
    // Compare and bus tasks
    // ****************************************
    task automatic chk_word(input string nm, input logic [13:0] exp, input logic [13:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit
    task automatic reg_write(input logic [15:0] a, input logic [13:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    // Read data stand only in the cycle after the strobe, so they are looked at there
    task automatic reg_read(input logic [15:0] a, input logic [13:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk_word("reg_rdata", exp, reg_rdata);
    endtask : reg_read
    task automatic self_write(input logic [12:0] a);
        @(posedge core_clk);
        cpu_pm_wr_req <= 1'b1;
        cpu_pm_wr_addr <= a;
        @(posedge core_clk);
        cpu_pm_wr_req <= 1'b0;
        #1;
    endtask : self_write
    task automatic fault_pulse();
        @(posedge core_clk);
        stack_fault <= 1'b1;
        @(posedge core_clk);
        stack_fault <= 1'b0;
        #1;
    endtask : fault_pulse
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge core_clk);
        chk_bit("freq_mult_en", 1'b1, freq_mult_en);
        rst_n <= 1'b1;
        reg_read(CFG2_ADDR, 14'h3FFF);
        reg_read(DEV_REV_ADDR, {T_DEV, T_REV});
        reg_read(16'h8005, 14'h0000);
        $display("Test reset done");
        // Self-write size rows, reserved bits forced to one on read-back
        for (int i = 0; i < 6; i++) begin
            reg_write(CFG2_ADDR, 14'h1000 | 14'(SW_SZ[i]));
            reg_read(CFG2_ADDR, 14'h18FC | 14'(SW_SZ[i]));
            chk_bit("freq_mult_en", 1'b0, freq_mult_en);
            self_write(SW_AD[i]);
            chk_bit("grant", SW_OK[i], cpu_pm_wr_grant);
            chk_bit("refused", !SW_OK[i], cpu_pm_wr_refused);
        end
        $display("Test self-write rows done");
        // Stack fault with the enable low, then high
        fault_pulse();
        chk_bit("stack_fault_reset", 1'b0, stack_fault_reset);
        reg_read(STATUS_ADDR, 14'h0002);
        reg_write(STATUS_ADDR, 14'h0002);
        reg_read(STATUS_ADDR, 14'h0000);
        reg_write(CFG2_ADDR, 14'h3FFF);
        fault_pulse();
        chk_bit("stack_fault_reset", 1'b1, stack_fault_reset);
        $display("Test stack fault done");
        // Every protect setting against every external access kind
        for (int p = 0; p < 4; p++) begin
            reg_write(PROTECT_ADDR, 14'(p));
            for (int k = 0; k < 5; k++) begin
                pm_o = p[0];
                ee_o = p[1];
                TOOL.access(k);
                #1;
                chk_word("ext_pm_rdata", (k == 0 && pm_o) ? TOOL.PM_WORD : 14'h0000,
                         ext_pm_rdata);
                chk_bit("ext_pm_wr_en", k == 1 && pm_o, ext_pm_wr_en);
                chk_word("ext_ee_rdata", (k == 2 && ee_o) ? 14'(TOOL.EE_BYTE) : 14'h0000,
                         14'(ext_ee_rdata));
                chk_bit("ext_ee_wr_en", k == 3 && ee_o, ext_ee_wr_en);
                chk_bit("ext_refused", (k < 2 && !pm_o) || ((k == 2 || k == 3) && !ee_o),
                        ext_refused);
                chk_word("ext_id_rdata", (k == 4) ? {T_DEV, T_REV} : 14'h0000,
                         ext_id_rdata);
            end
        end
        reg_read(STATUS_ADDR, 14'h0003);
        $display("Test external protection done");
        // Full code protection leaves CPU self-writes to the size field alone
        reg_write(PROTECT_ADDR, 14'h0000);
        self_write(13'h0000);
        chk_bit("grant", 1'b1, cpu_pm_wr_grant);
        // User words, read-only identity and a read-back of each word
        for (int u = 0; u < 4; u++)
            reg_write(USER_ID_BASE + 16'(u), 14'h1230 + 14'(u));
        reg_write(DEV_REV_ADDR, 14'h0000);
        for (int u = 0; u < 4; u++)
            reg_read(USER_ID_BASE + 16'(u), 14'h1230 + 14'(u));
        reg_read(DEV_REV_ADDR, {T_DEV, T_REV});
        $display("Test user words done");
        // Write then read with no gap; the read sees the new word
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, USER_ID_LAST, 14'h0ABC};
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'b01;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk_word("reg_rdata", 14'h0ABC, reg_rdata);
        // A fault in the clearing cycle keeps its status bit
        fork
            reg_write(STATUS_ADDR, 14'h0003);
            fault_pulse();
        join
        reg_read(STATUS_ADDR, 14'h0002);
        $display("Test awkward cases done");
        // Mid-run reset restores blank words, open protection, clear status
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        reg_read(USER_ID_BASE, 14'h3FFF);
        reg_read(PROTECT_ADDR, 14'h0003);
        reg_read(STATUS_ADDR, 14'h0000);
        $display("Test mid-run reset done");
        print_verdict();
    end
endmodule : testbench
